//--- include/cmw_pkg.sv
// Package of constants and types for the CAN transceiver mode and wake block
package cmw_pkg;

    // ****************************************************
    // Timing
    // ****************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int WAKE_DOMINANT_TIME_NS = 1000;
    localparam int WAKE_RECESSIVE_TIME_NS = 1000;
    localparam int WAKE_PATTERN_TIMEOUT_US = 5000;
    localparam int SELECT_FILTER_TIME_NS = 2000;
    localparam int WAKE_DOM_CYC =
        (WAKE_DOMINANT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_REC_CYC =
        (WAKE_RECESSIVE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_TO_CYC =
        (WAKE_PATTERN_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
    localparam int SEL_FLT_CYC =
        (SELECT_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;
    localparam int TO_W = 20;

    // ****************************************************
    // Buffer
    // ****************************************************
    localparam int BUF_DEPTH = 2;

    // ****************************************************
    // Types
    // ****************************************************
    typedef enum logic [1:0] {
        CMW_OFF,
        CMW_STANDBY,
        CMW_NORMAL
    } cmw_mode_t;

    typedef enum logic [1:0] {
        CMW_WK_IDLE,
        CMW_WK_DOM1,
        CMW_WK_REC,
        CMW_WK_DOM2
    } cmw_wake_t;

endpackage

//--- src/cmw_buf.sv
// Two-entry valid/ready buffer for received bus levels
`timescale 1ns/1ns
module cmw_buf (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Fill side
    input wire logic in_valid_in,
    input wire logic in_data_in,
    output logic in_ready_out,
    // Drain side
    output logic out_valid_out,
    output logic out_data_out,
    input wire logic out_ready_in
);
    logic [cmw_pkg::BUF_DEPTH-1:0] mem_q;
    logic wr_ptr_q;
    logic rd_ptr_q;
    logic [1:0] count_q;
    logic push;
    logic pop;

    assign in_ready_out = (count_q != 2'h2);
    assign out_valid_out = (count_q != 2'h0);
    assign out_data_out = mem_q[rd_ptr_q];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            mem_q <= '1;
        end else if (push) begin
            mem_q[wr_ptr_q] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

//--- src/cmw_top.sv
// Mode control, bus drive mapping and bus wake-up detection
`timescale 1ns/1ns
module cmw_top (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Supply monitors, high when the supply is above its threshold; io_variant_in marks a part with an I/O supply pin
    input wire logic main_supply_ok_in,
    input wire logic main_supply_standby_ok_in,
    input wire logic io_supply_ok_in,
    input wire logic io_variant_in,
    // Controller side
    input wire logic standby_select_in,
    input wire logic tx_data_in,
    output logic rx_data_out,
    output logic rx_data_oe_out,
    // Bus side
    input wire logic bus_dominant_in,
    output logic bus_drive_dominant_out,
    output logic bus_bias_normal_out,
    output logic bus_bias_ground_out,
    output logic bus_oe_out,
    output logic lp_receiver_on_out,
    output logic wake_detected_out,
    output logic [1:0] mode_out
);

    // ****************************************************
    // Select filter
    // ****************************************************
    logic sel_filt_q;
    logic [cmw_pkg::CNT_W-1:0] sel_cnt_q;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sel_filt_q <= 1'b1;
            sel_cnt_q <= '0;
        end else if (standby_select_in == sel_filt_q) begin
            sel_cnt_q <= '0;
        end else if (sel_cnt_q ==
                     cmw_pkg::CNT_W'(cmw_pkg::SEL_FLT_CYC - 1)) begin
            sel_filt_q <= standby_select_in;
            sel_cnt_q <= '0;
        end else begin
            sel_cnt_q <= sel_cnt_q + 1'b1;
        end
    end

    // ****************************************************
    // Mode selection
    // ****************************************************
    cmw_pkg::cmw_mode_t mode_q;
    cmw_pkg::cmw_mode_t mode_d;
    logic io_good;

    // Without an I/O supply pin the main supply feeds the I/O side
    assign io_good = io_variant_in ? io_supply_ok_in : main_supply_ok_in;

    always_comb begin
        if (!io_good) begin
            mode_d = cmw_pkg::CMW_OFF;
        end else if (!main_supply_standby_ok_in ||
                     (io_variant_in && !main_supply_ok_in)) begin
            mode_d = cmw_pkg::CMW_STANDBY;
        end else if (sel_filt_q) begin
            mode_d = cmw_pkg::CMW_STANDBY;
        end else begin
            mode_d = cmw_pkg::CMW_NORMAL;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            mode_q <= cmw_pkg::CMW_OFF;
        end else begin
            mode_q <= mode_d;
        end
    end

    logic enter_standby;
    assign enter_standby = (mode_d == cmw_pkg::CMW_STANDBY) &&
                           (mode_q != cmw_pkg::CMW_STANDBY);

    // ****************************************************
    // Wake-up pattern detector
    // ****************************************************
    cmw_pkg::cmw_wake_t wk_q;
    logic [cmw_pkg::CNT_W-1:0] ph_cnt_q;
    logic [cmw_pkg::TO_W-1:0] to_cnt_q;
    logic wake_q;
    logic in_standby;
    logic dom_done;
    logic rec_done;
    logic timed_out;

    assign in_standby = (mode_q == cmw_pkg::CMW_STANDBY);

    function automatic logic reached(input logic [cmw_pkg::CNT_W-1:0] c,
                                     input int n);
        reached = (c >= cmw_pkg::CNT_W'(n - 1));
    endfunction

    assign dom_done = bus_dominant_in &&
                      reached(ph_cnt_q, cmw_pkg::WAKE_DOM_CYC);
    assign rec_done = !bus_dominant_in &&
                      reached(ph_cnt_q, cmw_pkg::WAKE_REC_CYC);
    assign timed_out = (wk_q != cmw_pkg::CMW_WK_IDLE) &&
        (to_cnt_q >= cmw_pkg::TO_W'(cmw_pkg::WAKE_TO_CYC - 1));

    // Phase counter runs while the bus holds the level the state awaits;
    // in the recessive and second dominant phases a short opposite interval clears it without moving the state, in the first it returns to idle
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wk_q <= cmw_pkg::CMW_WK_IDLE;
            ph_cnt_q <= '0;
        end else if (!in_standby || enter_standby || timed_out) begin
            wk_q <= cmw_pkg::CMW_WK_IDLE;
            ph_cnt_q <= '0;
        end else begin
            case (wk_q)
                cmw_pkg::CMW_WK_IDLE: begin
                    if (bus_dominant_in) begin
                        wk_q <= cmw_pkg::CMW_WK_DOM1;
                        ph_cnt_q <= '0;
                    end
                end
                cmw_pkg::CMW_WK_DOM1: begin
                    if (!bus_dominant_in) begin
                        wk_q <= cmw_pkg::CMW_WK_IDLE;
                        ph_cnt_q <= '0;
                    end else if (dom_done) begin
                        wk_q <= cmw_pkg::CMW_WK_REC;
                        ph_cnt_q <= '0;
                    end else begin
                        ph_cnt_q <= ph_cnt_q + 1'b1;
                    end
                end
                cmw_pkg::CMW_WK_REC: begin
                    if (bus_dominant_in) begin
                        ph_cnt_q <= '0;
                    end else if (rec_done) begin
                        wk_q <= cmw_pkg::CMW_WK_DOM2;
                        ph_cnt_q <= '0;
                    end else begin
                        ph_cnt_q <= ph_cnt_q + 1'b1;
                    end
                end
                cmw_pkg::CMW_WK_DOM2: begin
                    if (!bus_dominant_in) begin
                        ph_cnt_q <= '0;
                    end else if (dom_done) begin
                        wk_q <= cmw_pkg::CMW_WK_IDLE;
                        ph_cnt_q <= '0;
                    end else begin
                        ph_cnt_q <= ph_cnt_q + 1'b1;
                    end
                end
                default: begin
                    wk_q <= cmw_pkg::CMW_WK_IDLE;
                    ph_cnt_q <= '0;
                end
            endcase
        end
    end

    // Timeout runs from the start of the first dominant phase
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            to_cnt_q <= '0;
        end else if (wk_q == cmw_pkg::CMW_WK_IDLE || !in_standby) begin
            to_cnt_q <= '0;
        end else begin
            to_cnt_q <= to_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wake_q <= 1'b0;
        end else if (!in_standby || enter_standby) begin
            wake_q <= 1'b0;
        end else if (wk_q == cmw_pkg::CMW_WK_DOM2 && dom_done &&
                     !timed_out) begin
            wake_q <= 1'b1;
        end
    end

    // ****************************************************
    // Receive path through the buffer
    // ****************************************************
    logic rx_level;
    logic buf_in_ready;
    logic buf_valid;
    logic buf_data;
    logic rx_q;
    logic rx_oe_q;

    always_comb begin
        case (mode_q)
            cmw_pkg::CMW_NORMAL:
                rx_level = !(bus_dominant_in || !tx_data_in);
            cmw_pkg::CMW_STANDBY:
                rx_level = wake_q ? !bus_dominant_in : 1'b1;
            default:
                rx_level = 1'b1;
        endcase
    end

    cmw_buf u_buf (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .in_valid_in(1'b1),
        .in_data_in(rx_level),
        .in_ready_out(buf_in_ready),
        .out_valid_out(buf_valid),
        .out_data_out(buf_data),
        .out_ready_in(1'b1)
    );

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_q <= 1'b1;
            rx_oe_q <= 1'b0;
        end else begin
            if (buf_valid) begin
                rx_q <= buf_data;
            end
            rx_oe_q <= (mode_q != cmw_pkg::CMW_OFF);
        end
    end

    // ****************************************************
    // Bus drive
    // ****************************************************
    logic drv_q;
    logic bias_n_q;
    logic bias_g_q;
    logic bus_oe_q;
    logic lp_q;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            drv_q <= 1'b0;
            bias_n_q <= 1'b0;
            bias_g_q <= 1'b0;
            bus_oe_q <= 1'b0;
            lp_q <= 1'b0;
        end else begin
            drv_q <= (mode_d == cmw_pkg::CMW_NORMAL) && !tx_data_in
                     && buf_in_ready;
            bias_n_q <= (mode_d == cmw_pkg::CMW_NORMAL);
            bias_g_q <= (mode_d == cmw_pkg::CMW_STANDBY);
            bus_oe_q <= (mode_d != cmw_pkg::CMW_OFF);
            lp_q <= (mode_d == cmw_pkg::CMW_STANDBY);
        end
    end

    assign rx_data_out = rx_q;
    assign rx_data_oe_out = rx_oe_q;
    assign bus_drive_dominant_out = drv_q;
    assign bus_bias_normal_out = bias_n_q;
    assign bus_bias_ground_out = bias_g_q;
    assign bus_oe_out = bus_oe_q;
    assign lp_receiver_on_out = lp_q;
    assign wake_detected_out = wake_q;
    assign mode_out = mode_q;

endmodule

//--- verif/cmw_assertions.sv
// Checker of mode, drive and wake relations at the top ports
`timescale 1ns/1ns
module cmw_assertions (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Supplies and controller side
    input wire logic main_supply_ok_in,
    input wire logic main_supply_standby_ok_in,
    input wire logic io_supply_ok_in,
    input wire logic io_variant_in,
    input wire logic standby_select_in,
    input wire logic tx_data_in,
    input wire logic rx_data_out,
    input wire logic rx_data_oe_out,
    // Bus side
    input wire logic bus_dominant_in,
    input wire logic bus_drive_dominant_out,
    input wire logic bus_bias_normal_out,
    input wire logic bus_bias_ground_out,
    input wire logic bus_oe_out,
    input wire logic lp_receiver_on_out,
    input wire logic wake_detected_out,
    input wire logic [1:0] mode_out
);
    // ****************
    // Helper counters
    // ****************
    logic [7:0] sel_low_q;
    logic [7:0] dom_run_q;
    logic supply_good;
    assign supply_good = main_supply_ok_in && main_supply_standby_ok_in
        && (io_variant_in ? io_supply_ok_in : 1'b1);
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sel_low_q <= 8'h00;
        end else begin
            sel_low_q <= standby_select_in ? 8'h00
                : sel_low_q + {7'h00, sel_low_q != 8'hFF};
        end
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            dom_run_q <= 8'h00;
        end else begin
            dom_run_q <= !bus_dominant_in ? 8'h00
                : dom_run_q + {7'h00, dom_run_q != 8'hFF};
        end
    end
    // ****************
    // Assertions
    // ****************
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    off_bus_hiz_a: assert property (
        (mode_out == 2'h0)[*2] |-> !bus_oe_out) else $error("bus engaged");
    off_rx_hiz_a: assert property (
        (mode_out == 2'h0)[*4] |-> !rx_data_oe_out) else $error("rx driven");
    main_off_a: assert property (
        !io_variant_in && !main_supply_ok_in |=> mode_out == 2'h0)
        else $error("not off on main supply loss");
    io_off_a: assert property (
        io_variant_in && !io_supply_ok_in |=> mode_out == 2'h0)
        else $error("not off on io supply loss");
    io_standby_a: assert property (
        io_variant_in && io_supply_ok_in && !main_supply_ok_in
        |=> mode_out == 2'h1) else $error("not standby on main loss");
    drive_dom_a: assert property (
        (mode_out == 2'h2 && !tx_data_in)[*2] |-> bus_drive_dominant_out)
        else $error("no dominant drive");
    standby_quiet_a: assert property (
        (mode_out == 2'h1)[*2] |-> !bus_drive_dominant_out
        && bus_bias_ground_out && lp_receiver_on_out && !bus_bias_normal_out)
        else $error("standby outputs wrong");
    rx_idle_a: assert property (
        (mode_out == 2'h1 && !wake_detected_out)[*5] |-> rx_data_out)
        else $error("rx low before wake");
    normal_entry_a: assert property (
        $rose(mode_out == 2'h2) |-> sel_low_q >= 8'(cmw_pkg::SEL_FLT_CYC))
        else $error("select not filtered");
    normal_sel_a: assert property (
        (supply_good && sel_low_q >= 8'h18)[*2] |-> mode_out == 2'h2)
        else $error("normal not entered");
    wake_pattern_a: assert property (
        $rose(wake_detected_out) |-> mode_out == 2'h1
        && $past(dom_run_q) >= 8'(cmw_pkg::WAKE_DOM_CYC - 1))
        else $error("wake without pattern");
    wake_clear_a: assert property (
        (mode_out != 2'h1)[*2] |-> !wake_detected_out)
        else $error("wake flag kept");
    cover property ($rose(wake_detected_out));
    cover property ($rose(mode_out == 2'h2));
    cover property (mode_out == 2'h0 ##1 mode_out == 2'h1);
endmodule

bind cmw_top cmw_assertions u_chk (
    .clk_in(clk_in), .rst_in(rst_in),
    .main_supply_ok_in(main_supply_ok_in),
    .main_supply_standby_ok_in(main_supply_standby_ok_in),
    .io_supply_ok_in(io_supply_ok_in), .io_variant_in(io_variant_in),
    .standby_select_in(standby_select_in), .tx_data_in(tx_data_in),
    .rx_data_out(rx_data_out), .rx_data_oe_out(rx_data_oe_out),
    .bus_dominant_in(bus_dominant_in),
    .bus_drive_dominant_out(bus_drive_dominant_out),
    .bus_bias_normal_out(bus_bias_normal_out),
    .bus_bias_ground_out(bus_bias_ground_out), .bus_oe_out(bus_oe_out),
    .lp_receiver_on_out(lp_receiver_on_out),
    .wake_detected_out(wake_detected_out), .mode_out(mode_out)
);

//--- verif/cmw_bus_model.sv
// Wired bus model joining this node's drive with remote nodes
`timescale 1ns/1ns
module cmw_bus_model (
    // Drivers
    input wire logic drive_dominant_in,
    input wire logic drive_oe_in,
    input wire logic remote_dominant_in,
    // Receiver view
    output logic bus_dominant_out
);
    // Dominant from any node wins over recessive
    assign bus_dominant_out = remote_dominant_in
        | (drive_dominant_in & drive_oe_in);
endmodule

//--- verif/tb_cmw_top.sv
// Self-checking bench for mode control and bus wake-up
`timescale 1ns/1ns
module tb_cmw_top;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic m_ok = 1'b1, s_ok = 1'b1, io_ok = 1'b1, var_in = 1'b0;
    logic sel = 1'b1, tx = 1'b1, remote = 1'b0;
    logic rx, rx_oe, bus_dom, drv, bn, bg, oe, lp, wk;
    logic [1:0] mode;
    int error_cnt = 0;
    int check_count = 0;

    always #50 clk_in = ~clk_in;

    cmw_top u_dut (
        .clk_in(clk_in), .rst_in(rst_in), .main_supply_ok_in(m_ok),
        .main_supply_standby_ok_in(s_ok), .io_supply_ok_in(io_ok),
        .io_variant_in(var_in), .standby_select_in(sel),
        .tx_data_in(tx), .rx_data_out(rx), .rx_data_oe_out(rx_oe),
        .bus_dominant_in(bus_dom), .bus_drive_dominant_out(drv),
        .bus_bias_normal_out(bn), .bus_bias_ground_out(bg),
        .bus_oe_out(oe), .lp_receiver_on_out(lp),
        .wake_detected_out(wk), .mode_out(mode)
    );
    cmw_bus_model u_bus (
        .drive_dominant_in(drv), .drive_oe_in(oe),
        .remote_dominant_in(remote), .bus_dominant_out(bus_dom)
    );

    // ****************
    // Helpers
    // ****************
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic phase(input logic d, input int n);
        remote = d;
        cyc(n);
    endtask
    task automatic chk(input logic [1:0] got, input logic [1:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [1:0] exp_mode(input logic v, m, s, i, sl);
        if (v ? !i : !m) return 2'h0;
        if (!m || !s) return 2'h1;
        return sl ? 2'h1 : 2'h2;
    endfunction
    task automatic results();
        $display("errors=%0d checks=%0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ****************
    // Tests
    // ****************
    initial begin
        int i;
        logic t, r;
        logic [1:0] e;
        void'($urandom(32'hCD372A6E));
        cyc(2);
        chk(mode, 2'h0);
        chk({oe, rx_oe}, 2'h0);
        rst_in = 1'b0;
        cyc(3);
        chk(mode, 2'h1);
        chk({bg, lp}, 2'h3);
        for (i = 0; i < 30; i++) phase(i[0], $urandom_range(8, 1));
        chk({wk, rx}, 2'h1);
        // Short intervals inside the recessive and second dominant phases
        phase(1'b1, 12);
        phase(1'b0, 4);
        phase(1'b1, 3);
        phase(1'b0, 12);
        phase(1'b1, 4);
        phase(1'b0, 3);
        chk({1'b0, wk}, 2'h0);
        phase(1'b1, 12);
        chk({1'b0, wk}, 2'h1);
        phase(1'b0, 5);
        chk({1'b0, rx}, 2'h1);
        phase(1'b1, 5);
        chk({1'b0, rx}, 2'h0);
        remote = 1'b0;
        // Select low for less than the filter time; tx stays high
        sel = 1'b0;
        cyc(10);
        chk(mode, 2'h1);
        sel = 1'b1;
        cyc(30);
        chk(mode, 2'h1);
        sel = 1'b0;
        cyc(25);
        chk(mode, 2'h2);
        chk({wk, oe}, 2'h1);
        chk({bn, bg}, 2'h2);
        for (i = 0; i < 20; i++) begin
            t = 1'($urandom_range(1));
            r = 1'($urandom_range(1));
            tx = t;
            remote = r;
            cyc(5);
            chk({1'b0, drv}, {1'b0, !t});
            chk({1'b0, rx}, {1'b0, !(r | !t)});
        end
        tx = 1'b1;
        remote = 1'b0;
        sel = 1'b1;
        cyc(25);
        chk({wk, rx}, 2'h1);
        for (i = 0; i < 8; i++) begin
            tx = 1'($urandom_range(1));
            cyc(3);
            chk({1'b0, drv}, 2'h0);
        end
        tx = 1'b1;
        phase(1'b1, 12);
        phase(1'b0, 12);
        cyc(50010);
        phase(1'b1, 12);
        chk({1'b0, wk}, 2'h0);
        remote = 1'b0;
        sel = 1'b0;
        for (i = 0; i < 16; i++) begin
            {var_in, m_ok, s_ok, io_ok} = 4'($urandom_range(15));
            e = exp_mode(var_in, m_ok, s_ok, io_ok, sel);
            cyc(25);
            chk(mode, e);
            if (e == 2'h0) chk({oe, rx_oe}, 2'h0);
        end
        results();
    end

    initial begin
        cyc(70000);
        error_cnt++;
        results();
    end
endmodule
